// ==== logic/vc_resource_pkg.sv ====
/*
  Constants, field layouts and carrier types for the virtual channel
  resource register bank (first channel plus the second channel's
  resource capability word).
  Assumes both register ports and the request checker share one clock.
*/
// Summary of operation
// - Reject set: snooped requests become unsupported
// - Reject resets 0, CPU writable, config read-only
// - First channel table offset reads zero
// - First channel maximum time slot reads zero
// - Six arbitration capability flags read zero
// - Channel enable always reads one, read-only
// - Channel identifier always reads 000, read-only
// - Arbitration select and load-table read zero
// - Class map bits 7..1 reset one, writable
// - Class 0 map bit always one
// - Negotiation pending read-only, initially one
// - Arbitration table status always reads zero
// - Reserved bits read zero from both ports
// - Second channel has own reject bit
// - Second channel offsets, slots, flags read zero
// - Arbitration table load bit reads zero
`default_nettype none
package vc_resource_pkg;

  // Register indexes, word addressed
  localparam logic [3:0] IDX_PORT_VC_CONTROL   = 4'h3;
  localparam logic [3:0] IDX_VC0_RES_CAP       = 4'h4;
  localparam logic [3:0] IDX_VC0_RES_CONTROL   = 4'h5;
  localparam logic [3:0] IDX_VC0_RES_STATUS    = 4'h6;
  localparam logic [3:0] IDX_SECOND_VC_RES_CAP = 4'h7;

  // Field positions
  localparam int BIT_SNOOP_REJECT   = 15;
  localparam int BIT_CHANNEL_ENABLE = 31;
  localparam int BIT_NEG_PENDING    = 17;
  localparam int BIT_TC_MAP_HI      = 7;
  localparam int BIT_TC_MAP_LO      = 1;

  // Reset values
  localparam logic [7:0]  TC_MAP_RESET        = 8'hFF;
  localparam logic        SNOOP_REJECT_RESET  = 1'b0;
  localparam logic        NEG_PENDING_RESET   = 1'b1;
  localparam logic [31:0] WORD_ZERO           = 32'h0000_0000;

  // One register access request
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [3:0]  index;
    logic [31:0] wdata;
  } reg_req_t;

  // Read answer, one cycle after the request
  typedef struct packed {
    logic        valid;
    logic [31:0] rdata;
  } reg_rsp_t;

endpackage : vc_resource_pkg
`default_nettype wire

// ==== logic/vc_resource_regs.sv ====
/*
  Virtual channel resource register bank with a CPU-side port, a
  configuration-access port and a snoop-rejection checker for incoming
  requests.
  Assumes requests arrive from logic on clk; no synchronisers needed.
*/
`timescale 1ns/10ps
`default_nettype none
module vc_resource_regs (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire vc_resource_pkg::reg_req_t cpu_req,
  output var  vc_resource_pkg::reg_rsp_t cpu_rsp,
  input  wire vc_resource_pkg::reg_req_t cfg_req,
  output var  vc_resource_pkg::reg_rsp_t cfg_rsp,
  input  wire logic                      tlp_valid,
  input  wire logic                      tlp_no_snoop,
  output logic                           tlp_unsupported,
  output logic [7:0]                     tc_map_vc0,
  output logic                           snoop_reject_vc0,
  output logic                           snoop_reject_vcx
);

  ////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    vc_resource_pkg::reg_rsp_t cpu_rsp;
    vc_resource_pkg::reg_rsp_t cfg_rsp;
    logic [7:0]                tc_map;
    logic                      rej0;
    logic                      rejx;
    logic                      neg_pending;
    logic                      unsup;
  } state_t;

  state_t st;
  state_t next_st;

  ////////////////////////////////////////////////////////////////////////
  // Read decode shared by both ports
  function automatic logic [31:0] read_word(input logic [3:0] idx, input state_t s);
    logic [31:0] w;
    w = vc_resource_pkg::WORD_ZERO;
    case (idx)
      vc_resource_pkg::IDX_VC0_RES_CAP: begin
        w[vc_resource_pkg::BIT_SNOOP_REJECT] = s.rej0;
      end
      vc_resource_pkg::IDX_VC0_RES_CONTROL: begin
        w[vc_resource_pkg::BIT_CHANNEL_ENABLE] = 1'b1;
        w[7:0] = s.tc_map;
      end
      vc_resource_pkg::IDX_VC0_RES_STATUS: begin
        w[vc_resource_pkg::BIT_NEG_PENDING] = s.neg_pending;
      end
      vc_resource_pkg::IDX_SECOND_VC_RES_CAP: begin
        w[vc_resource_pkg::BIT_SNOOP_REJECT] = s.rejx;
      end
      // load bit and all else zero
      vc_resource_pkg::IDX_PORT_VC_CONTROL: begin
        w = vc_resource_pkg::WORD_ZERO;
      end
      default: begin
        w = vc_resource_pkg::WORD_ZERO;
      end
    endcase
    return w;
  endfunction

  // True when a request writes the given register
  function automatic logic writes(input vc_resource_pkg::reg_req_t r, input logic [3:0] idx);
    return r.valid && r.write && (r.index == idx);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next state
  // Config writes apply first so a CPU write in the same cycle wins.
  always_comb begin
    next_st = st;
    next_st.cpu_rsp.valid = cpu_req.valid;
    next_st.cpu_rsp.rdata = cpu_req.valid ? read_word(cpu_req.index, st) : vc_resource_pkg::WORD_ZERO;
    next_st.cfg_rsp.valid = cfg_req.valid;
    next_st.cfg_rsp.rdata = cfg_req.valid ? read_word(cfg_req.index, st) : vc_resource_pkg::WORD_ZERO;
    // class map writable from config side
    if (writes(cfg_req, vc_resource_pkg::IDX_VC0_RES_CONTROL)) begin
      next_st.tc_map[vc_resource_pkg::BIT_TC_MAP_HI:vc_resource_pkg::BIT_TC_MAP_LO] =
        cfg_req.wdata[vc_resource_pkg::BIT_TC_MAP_HI:vc_resource_pkg::BIT_TC_MAP_LO];
    end
    // class map writable from CPU side
    if (writes(cpu_req, vc_resource_pkg::IDX_VC0_RES_CONTROL)) begin
      next_st.tc_map[vc_resource_pkg::BIT_TC_MAP_HI:vc_resource_pkg::BIT_TC_MAP_LO] =
        cpu_req.wdata[vc_resource_pkg::BIT_TC_MAP_HI:vc_resource_pkg::BIT_TC_MAP_LO];
    end
    // class 0 pinned to the first channel
    next_st.tc_map[0] = 1'b1;
    // reject bit only from the CPU side
    if (writes(cpu_req, vc_resource_pkg::IDX_VC0_RES_CAP)) begin
      next_st.rej0 = cpu_req.wdata[vc_resource_pkg::BIT_SNOOP_REJECT];
    end
    // second channel reject bit, CPU side only
    if (writes(cpu_req, vc_resource_pkg::IDX_SECOND_VC_RES_CAP)) begin
      next_st.rejx = cpu_req.wdata[vc_resource_pkg::BIT_SNOOP_REJECT];
    end
    next_st.neg_pending = st.neg_pending;
    // snooped request under rejection is unsupported
    next_st.unsup = tlp_valid && !tlp_no_snoop && st.rej0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Register the state
  always_ff @(posedge clk) begin
    if (rst) begin
      st.cpu_rsp     <= '0;
      st.cfg_rsp     <= '0;
      st.tc_map      <= vc_resource_pkg::TC_MAP_RESET;
      st.rej0        <= vc_resource_pkg::SNOOP_REJECT_RESET;
      st.rejx        <= vc_resource_pkg::SNOOP_REJECT_RESET;
      st.neg_pending <= vc_resource_pkg::NEG_PENDING_RESET;
      st.unsup       <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state flops
  assign cpu_rsp          = st.cpu_rsp;
  assign cfg_rsp          = st.cfg_rsp;
  assign tc_map_vc0       = st.tc_map;
  assign snoop_reject_vc0 = st.rej0;
  assign snoop_reject_vcx = st.rejx;
  assign tlp_unsupported  = st.unsup;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence snooped_tlp_s;
    tlp_valid && !tlp_no_snoop;
  endsequence

  sequence cfg_only_cap_write_s;
    writes(cfg_req, vc_resource_pkg::IDX_VC0_RES_CAP) && !writes(cpu_req, vc_resource_pkg::IDX_VC0_RES_CAP);
  endsequence

  sequence cpu_ctrl_write_s;
    writes(cpu_req, vc_resource_pkg::IDX_VC0_RES_CONTROL);
  endsequence

  sequence cfg_only_ctrl_write_s;
    writes(cfg_req, vc_resource_pkg::IDX_VC0_RES_CONTROL)
      && !writes(cpu_req, vc_resource_pkg::IDX_VC0_RES_CONTROL);
  endsequence

  sequence cfg_only_second_write_s;
    writes(cfg_req, vc_resource_pkg::IDX_SECOND_VC_RES_CAP)
      && !writes(cpu_req, vc_resource_pkg::IDX_SECOND_VC_RES_CAP);
  endsequence

  sequence cpu_second_write_s;
    writes(cpu_req, vc_resource_pkg::IDX_SECOND_VC_RES_CAP);
  endsequence

  // Rejection flags snooped requests one cycle later
  ur_on_reject_a: assert property ((snooped_tlp_s and snoop_reject_vc0) |=> tlp_unsupported)
    else $error("snooped request not flagged unsupported");

  // No flag unless rejection was on and the request snooped
  ur_only_cause_a: assert property (tlp_unsupported |-> $past(tlp_valid && !tlp_no_snoop && snoop_reject_vc0))
    else $error("unsupported flag without cause");

  // Config writes never move the reject bit
  reject_cfg_ro_a: assert property (cfg_only_cap_write_s |=> $stable(snoop_reject_vc0))
    else $error("config write changed reject bit");

  // CPU write lands in the reject bit
  reject_cpu_rw_a: assert property (writes(cpu_req, vc_resource_pkg::IDX_VC0_RES_CAP)
    |=> snoop_reject_vc0 == $past(cpu_req.wdata[vc_resource_pkg::BIT_SNOOP_REJECT]))
    else $error("CPU write to reject bit lost");

  // Capability read shows only the reject bit
  cap_read_fields_a: assert property (cpu_req.valid && !cpu_req.write && cpu_req.index == vc_resource_pkg::IDX_VC0_RES_CAP
    |=> cpu_rsp.valid && cpu_rsp.rdata == {16'h0000, $past(snoop_reject_vc0), 15'h0000})
    else $error("capability word has stray bits");

  // Control read: enable one, id and select zero
  ctrl_read_a: assert property (cfg_req.valid && cfg_req.index == vc_resource_pkg::IDX_VC0_RES_CONTROL
    |=> cfg_rsp.rdata[31:8] == 24'h80_0000 && cfg_rsp.rdata[0])
    else $error("control word fixed fields wrong");

  // CPU class map write updates bits 7..1 and keeps class 0
  tc_map_write_a: assert property (cpu_ctrl_write_s |=> tc_map_vc0 == {$past(cpu_req.wdata[7:1]), 1'b1})
    else $error("class map write not applied");

  // Class 0 bit never drops
  tc0_fixed_a: assert property (tc_map_vc0[0])
    else $error("class 0 unmapped");

  // Status word holds only pending flag, set
  status_read_a: assert property (cpu_req.valid && cpu_req.index == vc_resource_pkg::IDX_VC0_RES_STATUS
    |=> cpu_rsp.rdata == 32'h0002_0000)
    else $error("status word wrong");

  // Second channel word shows only its reject bit
  second_cap_read_a: assert property (cfg_req.valid && cfg_req.index == vc_resource_pkg::IDX_SECOND_VC_RES_CAP
    |=> cfg_rsp.rdata == {16'h0000, $past(snoop_reject_vcx), 15'h0000})
    else $error("second channel word wrong");

  // Port control and unmapped words read zero
  port_ctrl_zero_a: assert property (cpu_req.valid && (cpu_req.index == vc_resource_pkg::IDX_PORT_VC_CONTROL
    || cpu_req.index > vc_resource_pkg::IDX_SECOND_VC_RES_CAP) |=> cpu_rsp.rdata == 32'h0000_0000)
    else $error("zero word reads nonzero");

  ////////////////////////////////////////////////////////////////////////
  // Checks on the other port and on held state

  // Config class map write lands when the CPU is quiet
  tc_map_cfg_write_a: assert property (cfg_only_ctrl_write_s
    |=> tc_map_vc0 == {$past(cfg_req.wdata[7:1]), 1'b1})
    else $error("config class map write not applied");

  // Class map holds unless a port writes it
  tc_map_hold_a: assert property (!writes(cpu_req, vc_resource_pkg::IDX_VC0_RES_CONTROL)
    && !writes(cfg_req, vc_resource_pkg::IDX_VC0_RES_CONTROL) |=> $stable(tc_map_vc0))
    else $error("class map moved without a write");

  // Reject bit moves only on a CPU write, so stray config traffic is harmless
  reject_hold_a: assert property (!writes(cpu_req, vc_resource_pkg::IDX_VC0_RES_CAP)
    |=> $stable(snoop_reject_vc0))
    else $error("reject bit moved without a CPU write");

  // Config writes never move the second reject bit
  second_cfg_ro_a: assert property (cfg_only_second_write_s
    |=> $stable(snoop_reject_vcx))
    else $error("config write changed second reject bit");

  // CPU write lands in the second reject bit
  second_cpu_rw_a: assert property (cpu_second_write_s
    |=> snoop_reject_vcx == $past(cpu_req.wdata[vc_resource_pkg::BIT_SNOOP_REJECT]))
    else $error("CPU write to second reject bit lost");

  // Second reject bit holds unless the CPU writes it
  second_hold_a: assert property (!writes(cpu_req, vc_resource_pkg::IDX_SECOND_VC_RES_CAP)
    |=> $stable(snoop_reject_vcx))
    else $error("second reject bit moved without a CPU write");

  // Config view of the capability word shows only the reject bit
  cap_cfg_read_a: assert property (cfg_req.valid
    && cfg_req.index == vc_resource_pkg::IDX_VC0_RES_CAP
    |=> cfg_rsp.rdata == {16'h0000, $past(snoop_reject_vc0), 15'h0000})
    else $error("config capability word has stray bits");

  // CPU view of the control word, old value even on a write
  ctrl_cpu_read_a: assert property (cpu_req.valid
    && cpu_req.index == vc_resource_pkg::IDX_VC0_RES_CONTROL
    |=> cpu_rsp.rdata == {8'h80, 16'h0000, $past(tc_map_vc0)})
    else $error("CPU control word wrong");

  // Config view of the status word
  status_cfg_read_a: assert property (cfg_req.valid
    && cfg_req.index == vc_resource_pkg::IDX_VC0_RES_STATUS
    |=> cfg_rsp.rdata == 32'h0002_0000)
    else $error("config status word wrong");

  // CPU view of the second channel word
  second_cpu_read_a: assert property (cpu_req.valid
    && cpu_req.index == vc_resource_pkg::IDX_SECOND_VC_RES_CAP
    |=> cpu_rsp.rdata == {16'h0000, $past(snoop_reject_vcx), 15'h0000})
    else $error("CPU second channel word wrong");

  // Config view of port control and unmapped words
  cfg_zero_word_a: assert property (cfg_req.valid
    && (cfg_req.index == vc_resource_pkg::IDX_PORT_VC_CONTROL
    || cfg_req.index > vc_resource_pkg::IDX_SECOND_VC_RES_CAP)
    |=> cfg_rsp.rdata == 32'h0000_0000)
    else $error("config zero word reads nonzero");

  // Requests that carry no snoop always pass
  no_snoop_pass_a: assert property (tlp_valid && tlp_no_snoop
    |=> !tlp_unsupported)
    else $error("no snoop request flagged unsupported");

  // Second channel bit alone must not reject, the channel is unusable
  second_no_reject_a: assert property ((snooped_tlp_s and (!snoop_reject_vc0 && snoop_reject_vcx))
    |=> !tlp_unsupported)
    else $error("second channel bit rejected a request");

  // Every CPU access is answered next cycle
  cpu_ack_a: assert property (cpu_req.valid
    |=> cpu_rsp.valid)
    else $error("CPU access not answered");

  // Every config access is answered next cycle
  cfg_ack_a: assert property (cfg_req.valid
    |=> cfg_rsp.valid)
    else $error("config access not answered");

  // Idle CPU port shows no answer and a zero word
  cpu_idle_zero_a: assert property (!cpu_req.valid
    |=> !cpu_rsp.valid && cpu_rsp.rdata == vc_resource_pkg::WORD_ZERO)
    else $error("CPU answer without a request");

  // Idle config port shows no answer and a zero word
  cfg_idle_zero_a: assert property (!cfg_req.valid
    |=> !cfg_rsp.valid && cfg_rsp.rdata == vc_resource_pkg::WORD_ZERO)
    else $error("config answer without a request");

endmodule // vc_resource_regs
`default_nettype wire

// ==== test/link_requester.sv ====
/*
  Link-side partner: configuration requester and incoming request source.
  Assumes the bank samples requests on the rising edge of clk.
*/
`timescale 1ns/10ps
`default_nettype none
module link_requester (
  input  wire logic                      clk,
  output var  vc_resource_pkg::reg_req_t cfg_req,
  input  wire vc_resource_pkg::reg_rsp_t cfg_rsp,
  output var  logic                      tlp_valid,
  output var  logic                      tlp_no_snoop,
  input  wire logic                      tlp_unsupported
);
  // Idle from time zero
  initial begin
    cfg_req = '0;
    tlp_valid = 1'b0;
    tlp_no_snoop = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // caller data only
  task automatic cfg_acc(input logic wr, input logic [3:0] idx, input logic [31:0] wd, output logic [32:0] rd);
    @(negedge clk);
    cfg_req = {1'b1, wr, idx, wd};
    @(negedge clk);
    rd = {cfg_rsp.valid, cfg_rsp.rdata};
    // Released data inverted so a stale word never passes
    cfg_req = {2'b00, idx, ~wd};
  endtask

  // One request, answer sampled a cycle later
  task automatic send_tlp(input logic ns, output logic unsup);
    @(negedge clk);
    tlp_valid = 1'b1;
    tlp_no_snoop = ns;
    @(negedge clk);
    unsup = tlp_unsupported;
    tlp_valid = 1'b0;
    tlp_no_snoop = ~ns;
  endtask
endmodule // link_requester
`default_nettype wire

// ==== test/vc_resource_regs_tb_top.sv ====
/*
  Self-checking bench for the resource register bank.
  Assumes one 40 MHz clock and synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module vc_resource_regs_tb_top;
  logic                      clk;
  logic                      rst;
  vc_resource_pkg::reg_req_t cpu_req;
  vc_resource_pkg::reg_req_t cfg_req;
  vc_resource_pkg::reg_rsp_t cpu_rsp;
  vc_resource_pkg::reg_rsp_t cfg_rsp;
  logic                      tlp_valid;
  logic                      tlp_no_snoop;
  logic                      tlp_unsupported;
  logic [7:0]                tc_map_vc0;
  logic                      snoop_reject_vc0;
  logic                      snoop_reject_vcx;
  int                        errors;
  int                        comparisons;
  logic [32:0]               rd;
  logic                      u;
  // Reset words for indexes 3 to 7
  logic [31:0] rst_words [3:7] = '{32'h0, 32'h0, 32'h8000_00FF, 32'h0002_0000, 32'h0};

  vc_resource_regs DUT (.clk(clk), .rst(rst), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp), .cfg_req(cfg_req),
    .cfg_rsp(cfg_rsp), .tlp_valid(tlp_valid), .tlp_no_snoop(tlp_no_snoop), .tlp_unsupported(tlp_unsupported),
    .tc_map_vc0(tc_map_vc0), .snoop_reject_vc0(snoop_reject_vc0), .snoop_reject_vcx(snoop_reject_vcx));
  link_requester LINK (.clk(clk), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .tlp_valid(tlp_valid),
    .tlp_no_snoop(tlp_no_snoop), .tlp_unsupported(tlp_unsupported));

  // Free-running clock
  always #12.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // CPU access, held from one falling edge to the next
  task automatic cpu_acc(input logic wr, input logic [3:0] idx, input logic [31:0] wd, output logic [32:0] r);
    @(negedge clk);
    cpu_req = {1'b1, wr, idx, wd};
    @(negedge clk);
    r = {cpu_rsp.valid, cpu_rsp.rdata};
    cpu_req = {2'b00, idx, ~wd};
  endtask

  // Same word must read back from both ports
  task automatic rd_both(input logic [3:0] idx, input logic [31:0] exp);
    logic [32:0] r;
    cpu_acc(1'b0, idx, 32'h0, r);
    chk("cpu read", {1'b1, exp}, r);
    LINK.cfg_acc(1'b0, idx, 32'h0, r);
    chk("cfg read", {1'b1, exp}, r);
  endtask

  // Write from one port (1 = config side), then read back
  task automatic wr_chk(input logic p, input logic [3:0] idx, input logic [31:0] wd, input logic [31:0] exp);
    logic [32:0] r;
    if (p) begin
      LINK.cfg_acc(1'b1, idx, wd, r);
    end else begin
      cpu_acc(1'b1, idx, wd, r);
    end
    rd_both(idx, exp);
  endtask

  task automatic reset_words;
    for (int i = 3; i <= 7; i++) begin
      rd_both(i[3:0], rst_words[i]);
    end
    chk("tc map", 33'h0FF, {25'h0, tc_map_vc0});
  endtask

  task automatic final_report;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Whole run is under 120 cycles, so this is ample
  initial begin
    #(5000 * 25);
    errors++;
    final_report();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    cpu_req = '0;
    errors = 0;
    comparisons = 0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    reset_words();
    rd_both(4'hF, 32'h0);
    $display("test reset values done");
    // Write answer carries the old word
    cpu_acc(1'b1, 4'h5, 32'hFFFF_FF00, rd);
    chk("old word", {1'b1, 32'h8000_00FF}, rd);
    rd_both(4'h5, 32'h8000_0001);
    wr_chk(1'b1, 4'h5, 32'h0000_00A4, 32'h8000_00A5);
    chk("tc map", 33'h0A5, {25'h0, tc_map_vc0});
    wr_chk(1'b0, 4'h4, 32'hFFFF_FFFF, 32'h0000_8000);
    wr_chk(1'b1, 4'h4, 32'h0, 32'h0000_8000);
    wr_chk(1'b0, 4'h7, 32'h0000_8000, 32'h0000_8000);
    wr_chk(1'b1, 4'h7, 32'h0, 32'h0000_8000);
    chk("reject bits", 33'h3, {31'h0, snoop_reject_vc0, snoop_reject_vcx});
    wr_chk(1'b0, 4'h6, 32'hFFFF_FFFF, 32'h0002_0000);
    wr_chk(1'b1, 4'h3, 32'hFFFF_FFFF, 32'h0);
    $display("test write access done");
    LINK.send_tlp(1'b0, u);
    chk("snooped rejected", 33'h1, {32'h0, u});
    LINK.send_tlp(1'b1, u);
    chk("no snoop passes", 33'h0, {32'h0, u});
    // Second channel bit stays set: it must not reject
    wr_chk(1'b0, 4'h4, 32'h0, 32'h0);
    LINK.send_tlp(1'b0, u);
    chk("reject clear", 33'h0, {32'h0, u});
    $display("test request checker done");
    // Mid-run reset restores every word
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    reset_words();
    $display("test second reset done");
    final_report();
  end
endmodule // vc_resource_regs_tb_top
`default_nettype wire
